// >>> src/system_clock_mode_control.sv
// Purpose: main, peripheral, cpu and 1 kHz clock generation with crystal failover
// Assumes: oscillator inputs are levels synchronous to i_ref_clk; registers on a plain port
// Notes: clock outputs are registered levels; read data valid the cycle after i_rd_en
//
// Behaviour
// [RQ1] after reset the main clock runs from the internal high-frequency RC oscillator
// [RQ2] crystal failure switches main clock back to RC and raises a non-maskable interrupt; a crystal stuck high leaves the main clock parked on it
// [RQ3] crystal select bit: 0 picks the RC oscillator, 1 picks the crystal
// [RQ4] peripheral clock is always exactly half the main clock
// [RQ5] cpu select bit: 0 feeds cpu from peripheral clock, 1 from main clock
// [RQ6] during flash program or erase the cpu clock is forced to 12 MHz
// [RQ7] a software-set fractional-N divider makes 1 kHz from the 10 kHz RC oscillator
// [RQ8] RC trim in 0.3 MHz steps, calibrated by software against the crystal
// [RQ9] low-frequency RC trim in 0.5 kHz steps, set by software
// [RQ10] software waits 1 ms or 2 ms after crystal enable before using it
// [RQ11] a digital clock on the low-frequency pin may replace the 32 kHz crystal
// [RQ12] every clock switch is glitch-free with no truncated pulse; the lf timer clock select is a plain registered mux
`timescale 1ns/100ps
`include "clk_mode_params.svh"
module system_clock_mode_control
   import clk_mode_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_hf_rc_osc,
   input wire logic i_hf_xtal_osc,
   input wire logic i_lf_rc_osc,
   input wire logic i_lf_xtal_osc,
   input wire logic i_lf_clock_input_pin,
   input wire logic i_flash_busy,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   output logic [31:0] o_rd_data,
   output logic o_main_system_clock,
   output logic o_periph_clock,
   output logic o_cpu_core_clock,
   output logic o_ms_ref_clock,
   output logic o_lf_timer_clock,
   output logic o_lf_pin_digital,
   output logic o_xtal_fail_nmi,
   output logic [`HF_TRIM_W-1:0] o_hf_rc_trim,
   output logic [`LF_TRIM_W-1:0] o_lf_rc_trim
);

   // ==========================================
   // helpers
   function automatic logic rise(input logic cur, input logic prev);
      rise = cur && !prev;
   endfunction

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   localparam logic [7:0] FAIL_CYC = 8'(`XTAL_FAIL_CYC);

   // ==========================================
   // oscillator edge detection
   logic [2:0] osc_in;
   logic [2:0] osc_prev_r;
   logic [2:0] osc_rise;

   assign osc_in = {i_lf_rc_osc, i_hf_xtal_osc, i_hf_rc_osc};

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_edge
         always_ff @(posedge i_ref_clk or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               osc_prev_r[g] <= 1'b0;
            end
            else
            begin
               osc_prev_r[g] <= osc_in[g];
            end
         end
         assign osc_rise[g] = rise(osc_in[g], osc_prev_r[g]);
      end
   endgenerate

   // ==========================================
   // control registers
   logic xtal_sel_r;
   logic cpu_sel_r;
   logic lf_ext_r;
   logic xtal_fail_r;
   logic fail_event;
   logic [7:0] div_int_r;
   logic [7:0] div_frac_r;
   logic wr_ctrl;

   assign wr_ctrl = i_wr_en && hit(i_addr, `OFS_CLK_CTRL);

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         xtal_sel_r <= 1'b0; // RQ1
      end
      else if (fail_event)
      begin
         xtal_sel_r <= 1'b0; // RQ2
      end
      else if (wr_ctrl)
      begin
         xtal_sel_r <= i_wr_data[`CTRL_XTAL_SEL]; // RQ3
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cpu_sel_r <= 1'b0;
         lf_ext_r <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         cpu_sel_r <= i_wr_data[`CTRL_CPU_SEL]; // RQ5
         lf_ext_r <= i_wr_data[`CTRL_LF_EXT];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_hf_rc_trim <= `HF_TRIM_RST;
         o_lf_rc_trim <= `LF_TRIM_RST;
      end
      else if (i_wr_en)
      begin
         if (hit(i_addr, `OFS_HF_TRIM))
         begin
            o_hf_rc_trim <= i_wr_data[`HF_TRIM_W-1:0]; // RQ8
         end
         else if (hit(i_addr, `OFS_LF_TRIM))
         begin
            o_lf_rc_trim <= i_wr_data[`LF_TRIM_W-1:0]; // RQ9
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         div_int_r <= `MS_DIV_INT_RST;
         div_frac_r <= `MS_DIV_FRAC_RST;
      end
      else if (i_wr_en && hit(i_addr, `OFS_MS_DIV))
      begin
         div_int_r <= i_wr_data[15:8]; // RQ7
         div_frac_r <= i_wr_data[7:0];
      end
   end

   // ==========================================
   // crystal watchdog
   // counts reference cycles since the last crystal level change; a stuck
   // crystal in either level trips it, but one stuck high keeps the mux parked on it
   logic [7:0] xtal_quiet_r;
   logic main_on_xtal;

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         xtal_quiet_r <= 8'h00;
      end
      else if (i_hf_xtal_osc != osc_prev_r[1])
      begin
         xtal_quiet_r <= 8'h00;
      end
      else if (xtal_quiet_r != FAIL_CYC)
      begin
         xtal_quiet_r <= xtal_quiet_r + 8'h01;
      end
   end

   // only a crystal in use can fail; software waits out start-up before selecting
   assign fail_event = (xtal_sel_r || main_on_xtal) && (xtal_quiet_r == FAIL_CYC); // RQ2 RQ10

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         xtal_fail_r <= 1'b0;
      end
      else if (fail_event)
      begin
         xtal_fail_r <= 1'b1; // set wins over a clear in the same cycle
      end
      else if (i_wr_en && hit(i_addr, `OFS_CLK_STAT) && i_wr_data[`STAT_XTAL_FAIL])
      begin
         xtal_fail_r <= 1'b0;
      end
   end

   // one pulse per failure while the fail flag is clear, no software action needed to recover the clock from a crystal stopped low
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_xtal_fail_nmi <= 1'b0;
      end
      else
      begin
         o_xtal_fail_nmi <= fail_event && !xtal_fail_r; // RQ2
      end
   end

   // ==========================================
   // main, peripheral and cpu clocks
   logic main_prev_r;
   logic cpu_want_main;
   logic cpu_on_main;

   glitchless_clk_mux u_main_mux (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_clk_a(i_hf_rc_osc),
      .i_clk_b(i_hf_xtal_osc),
      .i_sel(xtal_sel_r), // RQ3 RQ12
      .o_clk(o_main_system_clock),
      .o_on_b(main_on_xtal)
   );

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         main_prev_r <= 1'b0;
         o_periph_clock <= 1'b0;
      end
      else
      begin
         main_prev_r <= o_main_system_clock;
         if (rise(o_main_system_clock, main_prev_r))
         begin
            o_periph_clock <= !o_periph_clock; // RQ4
         end
      end
   end

   // 12 MHz is the main clock on RC and the peripheral clock on the crystal
   always_comb
   begin
      if (i_flash_busy)
      begin
         cpu_want_main = !main_on_xtal; // RQ6
      end
      else
      begin
         cpu_want_main = cpu_sel_r; // RQ5
      end
   end

   glitchless_clk_mux u_cpu_mux (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_clk_a(o_periph_clock),
      .i_clk_b(o_main_system_clock),
      .i_sel(cpu_want_main), // RQ12
      .o_clk(o_cpu_core_clock),
      .o_on_b(cpu_on_main)
   );

   // ==========================================
   // low-frequency clocks
   frac_n_divider u_ms_div (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_tick(osc_rise[2]),
      .i_int(div_int_r),
      .i_frac(div_frac_r),
      .o_clk(o_ms_ref_clock) // RQ7
   );

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_lf_timer_clock <= 1'b0;
      end
      else
      begin
         o_lf_timer_clock <= lf_ext_r ? i_lf_clock_input_pin : i_lf_xtal_osc; // RQ11
      end
   end

   assign o_lf_pin_digital = lf_ext_r; // RQ11

   // ==========================================
   // calibration: count RC edges over a fixed number of crystal edges
   cal_state_t cal_state_r;
   logic [15:0] cal_xtal_r;
   logic [15:0] cal_hf_r;

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cal_state_r <= CAL_IDLE;
         cal_xtal_r <= 16'h0000;
         cal_hf_r <= 16'h0000;
      end
      else if (i_wr_en && hit(i_addr, `OFS_CAL_CTRL) && i_wr_data[`CAL_START])
      begin
         cal_state_r <= CAL_RUN; // RQ8
         cal_xtal_r <= 16'h0000;
         cal_hf_r <= 16'h0000;
      end
      else
      begin
         case (cal_state_r)
            CAL_RUN:
            begin
               cal_hf_r <= cal_hf_r + {15'h0000, osc_rise[0]}; // RQ8
               cal_xtal_r <= cal_xtal_r + {15'h0000, osc_rise[1]};
               if (cal_xtal_r == `CAL_XTAL_EDGES)
               begin
                  cal_state_r <= CAL_DONE;
               end
            end
            default:
            begin
               cal_state_r <= cal_state_r;
            end
         endcase
      end
   end

   // ==========================================
   // read port, data in the cycle after the strobe
   logic [31:0] rd_nxt;

   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      if (hit(i_addr, `OFS_CLK_CTRL))
      begin
         rd_nxt[`CTRL_XTAL_SEL] = xtal_sel_r;
         rd_nxt[`CTRL_CPU_SEL] = cpu_sel_r;
         rd_nxt[`CTRL_LF_EXT] = lf_ext_r;
      end
      else if (hit(i_addr, `OFS_CLK_STAT))
      begin
         rd_nxt[`STAT_ON_XTAL] = main_on_xtal;
         rd_nxt[`STAT_CPU_FAST] = cpu_on_main;
         rd_nxt[`STAT_XTAL_FAIL] = xtal_fail_r;
         rd_nxt[`STAT_FLASH_FORCE] = i_flash_busy;
      end
      else if (hit(i_addr, `OFS_HF_TRIM))
      begin
         rd_nxt[`HF_TRIM_W-1:0] = o_hf_rc_trim;
      end
      else if (hit(i_addr, `OFS_LF_TRIM))
      begin
         rd_nxt[`LF_TRIM_W-1:0] = o_lf_rc_trim;
      end
      else if (hit(i_addr, `OFS_MS_DIV))
      begin
         rd_nxt[15:0] = {div_int_r, div_frac_r};
      end
      else if (hit(i_addr, `OFS_CAL_RES))
      begin
         rd_nxt[15:0] = cal_hf_r;
         rd_nxt[`CAL_DONE] = (cal_state_r == CAL_DONE);
         rd_nxt[`CAL_BUSY] = (cal_state_r == CAL_RUN);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_rd_data <= 32'h0000_0000;
      end
      else if (i_rd_en)
      begin
         o_rd_data <= rd_nxt;
      end
      else
      begin
         o_rd_data <= 32'h0000_0000;
      end
   end

endmodule

// >>> common/clk_mode_params.svh
// Purpose: offsets, field positions, reset values and timing counts of the clock control block
// Assumes: 32-bit register port, byte addresses, 100 MHz reference clock
// Notes: definitions only
`ifndef CLK_MODE_PARAMS_SVH
`define CLK_MODE_PARAMS_SVH

// ==========================================
// register offsets
`define OFS_CLK_CTRL 8'h00
`define OFS_CLK_STAT 8'h04
`define OFS_HF_TRIM 8'h08
`define OFS_LF_TRIM 8'h0C
`define OFS_MS_DIV 8'h10
`define OFS_CAL_CTRL 8'h14
`define OFS_CAL_RES 8'h18

// ==========================================
// field positions
`define CTRL_XTAL_SEL 0
`define CTRL_CPU_SEL 1
`define CTRL_LF_EXT 2
`define STAT_ON_XTAL 0
`define STAT_CPU_FAST 1
`define STAT_XTAL_FAIL 2
`define STAT_FLASH_FORCE 3
`define CAL_START 0
`define CAL_DONE 16
`define CAL_BUSY 17

// ==========================================
// trim widths and reset values
`define HF_TRIM_W 6
`define LF_TRIM_W 5
`define HF_TRIM_RST 6'h20
`define LF_TRIM_RST 5'h10
`define MS_DIV_INT_RST 8'h0A
`define MS_DIV_FRAC_RST 8'h00

// ==========================================
// timing
`define REF_CLK_MHZ 100
`define XTAL_MHZ 24
`define XTAL_FAIL_NS 160
`define XTAL_FAIL_CYC (`XTAL_FAIL_NS * `REF_CLK_MHZ / 1000)
`define CAL_XTAL_EDGES 16'h00F0

`endif

// >>> common/clk_mode_pkg.sv
// Purpose: types shared by the clock control block
// Assumes: nothing
// Notes: one-hot state codes
package clk_mode_pkg;

   typedef enum logic [1:0] {
      SRC_A = 2'b01,
      SRC_B = 2'b10
   } mux_state_t;

   typedef enum logic [2:0] {
      CAL_IDLE = 3'b001,
      CAL_RUN = 3'b010,
      CAL_DONE = 3'b100
   } cal_state_t;

endpackage

// >>> src/glitchless_clk_mux.sv
// Purpose: two-input clock selector that never cuts a pulse short
// Assumes: both sources are levels sampled by i_ref_clk
// Notes: hands over only while old source, new source and output are all low
`timescale 1ns/100ps
module glitchless_clk_mux
   import clk_mode_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_clk_a,
   input wire logic i_clk_b,
   input wire logic i_sel,
   output logic o_clk,
   output logic o_on_b
);

   mux_state_t state_r;
   logic quiet;

   // ==========================================
   // hand-over: low phase may stretch, a high phase is never truncated
   assign quiet = !i_clk_a && !i_clk_b && !o_clk;

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_r <= SRC_A;
      end
      else
      begin
         case (state_r)
            SRC_A:
            begin
               if (i_sel && quiet)
               begin
                  state_r <= SRC_B; // RQ12
               end
            end
            SRC_B:
            begin
               if (!i_sel && quiet)
               begin
                  state_r <= SRC_A; // RQ12
               end
            end
            default:
            begin
               state_r <= SRC_A;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_clk <= 1'b0;
      end
      else
      begin
         o_clk <= (state_r == SRC_B) ? i_clk_b : i_clk_a;
      end
   end

   assign o_on_b = (state_r == SRC_B);

endmodule

// >>> src/frac_n_divider.sv
// Purpose: fractional-N divider of an input tick stream
// Assumes: i_tick is one cycle per source period
// Notes: period is int + frac/256 ticks on average
`timescale 1ns/100ps
module frac_n_divider
   import clk_mode_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_tick,
   input wire logic [7:0] i_int,
   input wire logic [7:0] i_frac,
   output logic o_clk
);

   logic [7:0] cnt_r;
   logic [7:0] acc_r;
   logic [8:0] acc_sum;
   logic [8:0] period;

   assign acc_sum = {1'b0, acc_r} + {1'b0, i_frac};
   // the carry lengthens this period by one tick to spread the fraction
   assign period = {1'b0, i_int} + {8'h00, acc_sum[8]};

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cnt_r <= 8'h00;
         acc_r <= 8'h00;
      end
      else if (i_tick)
      begin
         if ({1'b0, cnt_r} + 9'h001 >= period)
         begin
            cnt_r <= 8'h00;
            acc_r <= acc_sum[7:0]; // RQ7
         end
         else
         begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_clk <= 1'b0;
      end
      else
      begin
         o_clk <= ({1'b0, cnt_r} < {1'b0, period[8:1]}); // RQ7
      end
   end

endmodule

// >>> verification/system_clock_mode_control_assertions.sv
// Purpose: port-level checks of the clock control block
// Assumes: one 100 MHz domain, async active-low reset
// Notes: selections are tracked from register writes; clocks are checked once settled
`timescale 1ns/100ps
`include "clk_mode_params.svh"
module system_clock_mode_control_assertions
   import clk_mode_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_hf_rc_osc,
   input wire logic i_hf_xtal_osc,
   input wire logic i_flash_busy,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [31:0] o_rd_data,
   input wire logic o_main_system_clock,
   input wire logic o_periph_clock,
   input wire logic o_cpu_core_clock,
   input wire logic o_lf_pin_digital,
   input wire logic o_xtal_fail_nmi,
   input wire logic [`HF_TRIM_W-1:0] o_hf_rc_trim,
   input wire logic [`LF_TRIM_W-1:0] o_lf_rc_trim
);
   // ==========================================
   // selection tracking
   logic xsel_r, csel_r;
   logic [5:0] xcnt_r, ccnt_r;
   wire ctrl_wr = i_wr_en && (i_addr == `OFS_CLK_CTRL);
   // counters start near saturation: each mux is already on its reset source in reset, rc for main and peripheral for cpu
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         xsel_r <= 1'b0;
         xcnt_r <= 6'h3C;
      end
      else if (o_xtal_fail_nmi || (ctrl_wr && i_wr_data[0] != xsel_r))
      begin
         xsel_r <= ctrl_wr && !o_xtal_fail_nmi ? i_wr_data[0] : 1'b0;
         xcnt_r <= 6'h0;
      end
      else if (xcnt_r != 6'h3F)
         xcnt_r <= xcnt_r + 6'h1;
   end
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         csel_r <= 1'b0;
         ccnt_r <= 6'h3C;
      end
      // held at zero while flash is busy: the first idle edge still shows the forced source
      else if (i_flash_busy || (ctrl_wr && i_wr_data[1] != csel_r))
      begin
         csel_r <= ctrl_wr ? i_wr_data[1] : csel_r;
         ccnt_r <= 6'h0;
      end
      else if (ccnt_r != 6'h3F)
         ccnt_r <= ccnt_r + 6'h1;
   end
   // ==========================================
   // properties
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   sequence main_rise_s;
      $rose(o_main_system_clock);
   endsequence
   sequence per_step_s;
      ##1 $changed(o_periph_clock);
   endsequence
   main_source_a: assert property (
      xcnt_r == 6'h3F |-> o_main_system_clock == (xsel_r ? $past(i_hf_xtal_osc)
      : $past(i_hf_rc_osc))) else $error("main clock off its source");
   per_follow_a: assert property (
      main_rise_s |-> per_step_s) else $error("peripheral clock missed a step");
   per_only_a: assert property (
      $changed(o_periph_clock) |-> $past(o_main_system_clock)
      && !$past(o_main_system_clock, 2)) else $error("peripheral clock stray step");
   cpu_select_a: assert property (
      ccnt_r == 6'h3F && !i_flash_busy |-> o_cpu_core_clock == (csel_r ?
      $past(o_main_system_clock) : $past(o_periph_clock))) else $error("cpu clock source");
   nmi_pulse_a: assert property (
      o_xtal_fail_nmi |=> !o_xtal_fail_nmi) else $error("nmi longer than one cycle");
   main_whole_a: assert property (
      main_rise_s |=> o_main_system_clock) else $error("main clock pulse cut");
   cpu_whole_a: assert property (
      $fell(o_cpu_core_clock) |=> !o_cpu_core_clock) else $error("cpu clock gap cut");
   rd_idle_a: assert property (
      !$past(i_rd_en) |-> o_rd_data == 32'h0) else $error("read data outside slot");
   hf_trim_a: assert property (
      i_wr_en && i_addr == `OFS_HF_TRIM |=> o_hf_rc_trim == $past(i_wr_data[5:0]))
      else $error("hf trim not written");
   lf_trim_a: assert property (
      i_wr_en && i_addr == `OFS_LF_TRIM |=> o_lf_rc_trim == $past(i_wr_data[4:0]))
      else $error("lf trim not written");
   lf_pin_a: assert property (
      ctrl_wr |=> o_lf_pin_digital == $past(i_wr_data[2])) else $error("pin mode");
endmodule

// >>> verification/osc_model.sv
// Purpose: oscillator levels feeding the clock control block
// Assumes: sampled by the 100 MHz block clock
// Notes: rates scaled to keep runs short; a stopped crystal rests low, as a dead one would
`timescale 1ns/100ps
module osc_model
(
   input wire logic i_ref_clk,
   input wire logic i_xtal_run,
   output logic o_hf_rc,
   output logic o_xtal,
   output logic o_lf_rc,
   output logic o_lf_xtal,
   output logic o_lf_pin
);
   int cnt = 0;
   initial {o_hf_rc, o_xtal, o_lf_rc, o_lf_xtal, o_lf_pin} = 5'h0;
   // crystal at twice the rc rate, so a forced 12 MHz shows as the rc rate
   always @(posedge i_ref_clk)
   begin
      cnt <= cnt + 1;
      o_hf_rc <= (cnt % 4 == 3) ? ~o_hf_rc : o_hf_rc;
      // stops only at a falling step, so its last high phase stays whole
      o_xtal <= (cnt % 2 == 1) ? (~o_xtal && i_xtal_run) : o_xtal;
      o_lf_rc <= (cnt % 10 == 9) ? ~o_lf_rc : o_lf_rc;
      o_lf_xtal <= (cnt % 15 == 14) ? ~o_lf_xtal : o_lf_xtal;
      o_lf_pin <= (cnt % 6 == 5) ? ~o_lf_pin : o_lf_pin;
   end
endmodule

// >>> verification/system_clock_mode_control_tb_top.sv
// Purpose: self-checking bench of the clock control block
// Assumes: rc period 8 cycles, crystal 4, lf rc 20, lf crystal 30, lf pin 12
// Notes: clock rates are judged by rising-edge counts with one edge of slack
`timescale 1ns/100ps
`include "clk_mode_params.svh"
module system_clock_mode_control_tb_top
   import clk_mode_pkg::*;
();
   logic clk, rstn, xrun, busy, wr_en, rd_en;
   logic [7:0] addr;
   logic [31:0] wd;
   wire hf, xt, lr, lx, lp, main_c, per_c, cpu_c, ms_c, lft_c, lf_dig, nmi;
   wire [31:0] rd_data;
   wire [5:0] hft;
   wire [4:0] lft;
   wire [4:0] clks = {lft_c, ms_c, cpu_c, per_c, main_c};
   int error_cnt = 0;
   int compares = 0;
   osc_model i_osc(.i_ref_clk(clk), .i_xtal_run(xrun), .o_hf_rc(hf), .o_xtal(xt),
      .o_lf_rc(lr), .o_lf_xtal(lx), .o_lf_pin(lp));
   system_clock_mode_control i_dut(.i_ref_clk(clk), .i_resetn(rstn), .i_hf_rc_osc(hf),
      .i_hf_xtal_osc(xt), .i_lf_rc_osc(lr), .i_lf_xtal_osc(lx), .i_lf_clock_input_pin(lp),
      .i_flash_busy(busy), .i_addr(addr), .i_wr_data(wd), .i_wr_en(wr_en), .i_rd_en(rd_en),
      .o_rd_data(rd_data), .o_main_system_clock(main_c), .o_periph_clock(per_c),
      .o_cpu_core_clock(cpu_c), .o_ms_ref_clock(ms_c), .o_lf_timer_clock(lft_c),
      .o_lf_pin_digital(lf_dig), .o_xtal_fail_nmi(nmi), .o_hf_rc_trim(hft), .o_lf_rc_trim(lft));
   // ==========================================
   // helpers
   task automatic close_out();
      if (error_cnt == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic near(input int got, input int exp);
      compares++;
      if (got < exp - 1 || got > exp + 1)
      begin
         error_cnt++;
         $display("BAD %0t edge count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(posedge clk);
      d = rd_data;
   endtask
   task automatic rises(input int w, input int n, output int r);
      logic p, v;
      r = 0;
      p = 1'b1;
      repeat (n)
      begin
         @(posedge clk);
         v = clks[w];
         r += (v === 1'b1 && p === 1'b0);
         p = v;
      end
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset();
      logic [31:0] d;
      int n;
      reg_rd(`OFS_CLK_STAT, d);
      chk(d, 32'h0);
      reg_rd(`OFS_HF_TRIM, d);
      chk(d, {26'h0, `HF_TRIM_RST});
      reg_rd(`OFS_LF_TRIM, d);
      chk(d, {27'h0, `LF_TRIM_RST});
      reg_rd(`OFS_MS_DIV, d);
      chk(d, {16'h0, `MS_DIV_INT_RST, `MS_DIV_FRAC_RST});
      reg_rd(8'h1C, d);
      chk(d, 32'h0);
      rises(0, 400, n);
      near(n, 50);
   endtask
   task automatic t_modes();
      logic [31:0] d;
      int n, m;
      for (int k = 0; k < 4; k++)
      begin
         reg_wr(`OFS_CLK_CTRL, 32'(k));
         // the crystal runs from power-up, so a short settle stands for its start-up wait
         repeat (100) @(posedge clk);
         m = k[0] ? 100 : 50;
         rises(0, 400, n);
         near(n, m);
         rises(1, 400, n);
         near(n, m / 2);
         rises(2, 400, n);
         near(n, k[1] ? m : m / 2);
         reg_rd(`OFS_CLK_STAT, d);
         chk(d & 32'h3, 32'(k));
         busy <= 1'b1;
         repeat (100) @(posedge clk);
         rises(2, 400, n);
         near(n, 50);
         reg_rd(`OFS_CLK_STAT, d);
         chk(d & 32'h8, 32'h8);
         busy <= 1'b0;
      end
   endtask
   task automatic t_fail();
      logic [31:0] d;
      int n;
      reg_wr(`OFS_CLK_CTRL, 32'h1);
      repeat (100) @(posedge clk);
      xrun <= 1'b0;
      n = 0;
      while (nmi !== 1'b1 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, nmi}, 32'h1);
      repeat (60) @(posedge clk);
      reg_rd(`OFS_CLK_STAT, d);
      chk(d & 32'h5, 32'h4);
      reg_rd(`OFS_CLK_CTRL, d);
      chk(d & 32'h1, 32'h0);
      rises(0, 400, n);
      near(n, 50);
      reg_wr(`OFS_CLK_STAT, 32'h4);
      reg_rd(`OFS_CLK_STAT, d);
      chk(d & 32'h4, 32'h0);
      xrun <= 1'b1;
   endtask
   task automatic t_misc();
      logic [31:0] d;
      int n;
      reg_wr(`OFS_MS_DIV, 32'h0480);
      rises(3, 1800, n);
      near(n, 20);
      rises(4, 240, n);
      near(n, 8);
      reg_wr(`OFS_CLK_CTRL, 32'h4);
      repeat (4) @(posedge clk);
      chk({31'h0, lf_dig}, 32'h1);
      rises(4, 240, n);
      near(n, 20);
      reg_wr(`OFS_HF_TRIM, 32'h15);
      reg_wr(`OFS_LF_TRIM, 32'h07);
      @(posedge clk);
      chk({26'h0, hft}, 32'h15);
      chk({27'h0, lft}, 32'h07);
      reg_wr(`OFS_CAL_CTRL, 32'h1);
      n = 0;
      d = 32'h0;
      while (d[`CAL_DONE] !== 1'b1 && n < 400)
      begin
         reg_rd(`OFS_CAL_RES, d);
         n++;
      end
      chk(d & 32'h30000, 32'h10000);
      chk({31'h0, d[15:0] >= 16'h77 && d[15:0] <= 16'h79}, 32'h1);
   endtask
   // ==========================================
   // run
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      close_out();
   end
   initial
   begin
      rstn = 1'b0;
      xrun = 1'b1;
      busy = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wd = 32'h0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_modes();
      t_fail();
      t_misc();
      close_out();
   end
endmodule
bind system_clock_mode_control system_clock_mode_control_assertions i_chk(.i_ref_clk,
   .i_resetn, .i_hf_rc_osc, .i_hf_xtal_osc, .i_flash_busy, .i_addr, .i_wr_data, .i_wr_en,
   .i_rd_en, .o_rd_data, .o_main_system_clock, .o_periph_clock, .o_cpu_core_clock,
   .o_lf_pin_digital, .o_xtal_fail_nmi, .o_hf_rc_trim, .o_lf_rc_trim);
